// ### rtl/sram_port_regs.vh
`ifndef SRAM_PORT_REGS_VH
`define SRAM_PORT_REGS_VH

// Word organisation: four byte lanes, each with one parity bit
`define SRAM_LANES 4
`define SRAM_LANE_W 8
`define SRAM_DATA_W 32
`define SRAM_WORD_W 36
// Field positions inside a stored word
`define SRAM_PARITY_LSB 32
// Address width of the array
`define SRAM_ADDR_W 18
// Posted write queue depth and pointer width
`define SRAM_FIFO_DEPTH 16
`define SRAM_FIFO_PTR_W 4
// Burst order held from reset until the strap is taken: interleaved
`define SRAM_MODE_RESET 1'b1
// Burst group size in words, as a low-address field width
`define SRAM_BURST_BITS 2
// Access kinds held in the pipeline
`define SRAM_OP_DESEL 2'h0
`define SRAM_OP_READ 2'h1
`define SRAM_OP_WRITE 2'h2
// Pipeline latency from address edge to read data, in qualified edges
`define SRAM_READ_LATENCY 1

`endif

// ### rtl/sram_write_fifo.v
`timescale 1ns/1ps
// Posted write queue between the data pins and the array
module sram_write_fifo #(
  parameter WIDTH = 58,
  parameter DEPTH = 16,
  parameter PTR_W = 4
) (
  // Clock, reset and global freeze
  input wire core_clk,
  input wire reset,
  input wire clkEnable,
  // Filling side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Draining side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  // Storage array
  reg [WIDTH-1:0] store [0:DEPTH-1];
  // Read and write pointers
  reg [PTR_W-1:0] rdPtr;
  reg [PTR_W-1:0] wrPtr;
  // Occupancy, one bit wider than the pointers
  reg [PTR_W:0] count;
  wire doPush;
  wire doPop;

  // Honest flags straight from the occupancy
  assign inReady = (count != DEPTH[PTR_W:0]);
  assign outValid = (count != {(PTR_W+1){1'b0}});
  assign outData = store[rdPtr];
  // Transfers only happen while the block is not frozen
  assign doPush = clkEnable & inValid & inReady;
  assign doPop = clkEnable & outValid & outReady;

  // Data write, no reset needed on storage
  always @(posedge core_clk) begin
    if (doPush) begin
      store[wrPtr] <= inData;
    end
  end

  // Pointer and count update
  always @(posedge core_clk) begin
    if (reset) begin
      rdPtr <= {PTR_W{1'b0}};
      wrPtr <= {PTR_W{1'b0}};
      count <= {(PTR_W+1){1'b0}};
    end else begin
      // Pointers wrap naturally for power-of-two depth
      if (doPush) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      // Simultaneous push and pop leaves count alone
      if (doPush & ~doPop) begin
        count <= count + 1'b1;
      end else if (doPop & ~doPush) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ### rtl/sram_burst_counter.v
`timescale 1ns/1ps
`include "sram_port_regs.vh"
// Two-bit burst sequencer, linear or interleaved
module sram_burst_counter (
  // Clock, reset and edge qualifier
  input wire core_clk,
  input wire reset,
  input wire edgeOk,
  // Control
  input wire load,
  input wire advance,
  input wire interleave,
  input wire [`SRAM_BURST_BITS-1:0] startLow,
  // Current low address bits
  output wire [`SRAM_BURST_BITS-1:0] lowAddr
);
  // Start offset and beat count
  reg [`SRAM_BURST_BITS-1:0] start;
  reg [`SRAM_BURST_BITS-1:0] beat;

  // Only the low bits move and they wrap in a group of four
  assign lowAddr = interleave ? (start ^ beat) : (start + beat);

  // Load restarts the group, advance steps it
  always @(posedge core_clk) begin
    if (reset) begin
      start <= {`SRAM_BURST_BITS{1'b0}};
      beat <= {`SRAM_BURST_BITS{1'b0}};
    end else if (edgeOk) begin
      if (load) begin
        start <= startLow;
        beat <= {`SRAM_BURST_BITS{1'b0}};
      end else if (advance) begin
        // Counter steps on an advance edge
        beat <= beat + 1'b1;
      end
    end
  end
endmodule

// ### rtl/sync_burst_sram_port.v
`timescale 1ns/1ps
`include "sram_port_regs.vh"
module sync_burst_sram_port #(
  parameter ADDR_W = `SRAM_ADDR_W,
  parameter FIFO_DEPTH = `SRAM_FIFO_DEPTH,
  parameter FIFO_PTR_W = `SRAM_FIFO_PTR_W
) (
  // Clock, reset and global freeze
  input wire core_clk,
  input wire reset,
  input wire clkEnable,
  // Address pins
  input wire [ADDR_W-1:2] addrHigh,
  input wire burstAddrBit1,
  input wire burstAddrBit0,
  // Synchronous control pins
  input wire writeEnableN,
  input wire advanceOrLoad,
  input wire clockQualifyN,
  input wire chipSelFirstN,
  input wire chipSelSecond,
  input wire chipSelThirdN,
  // Byte lane write selects
  input wire laneAWriteSelN,
  input wire laneBWriteSelN,
  input wire laneCWriteSelN,
  input wire laneDWriteSelN,
  // Asynchronous output enable
  input wire outputEnableN,
  // Burst order strap
  input wire burstModeStrap,
  // Data pins, split into in, out and enable
  input wire [`SRAM_DATA_W-1:0] dataIn,
  output wire [`SRAM_DATA_W-1:0] dataOut,
  output wire dataOe,
  // Parity pins, split the same way
  input wire [`SRAM_LANES-1:0] parityPinsIn,
  output wire [`SRAM_LANES-1:0] parityPinsOut,
  output wire parityPinsOe,
  // Posted write queue can take another beat
  output wire writeQueueReady
);
  // Access kinds used as pipeline states
  localparam OP_DESEL = `SRAM_OP_DESEL;
  localparam OP_READ = `SRAM_OP_READ;
  localparam OP_WRITE = `SRAM_OP_WRITE;
  // Stored word and queue entry widths
  localparam WORD_W = `SRAM_WORD_W;
  localparam ENTRY_W = ADDR_W + `SRAM_LANES + WORD_W;
  localparam LANE_W = `SRAM_LANE_W;
  localparam PAR_LSB = `SRAM_PARITY_LSB;

  // The memory array itself
  reg [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Qualified edge: freeze input high and clock qualifier low
  wire edgeOk;
  // Chip selected by the sampled select pins
  wire selectNow;
  // Lane selects gathered, active high
  wire [`SRAM_LANES-1:0] laneSelNow;
  // Op decoded from pins at a load edge
  reg [1:0] next_loadOp;

  // Address phase state
  reg [1:0] opAddr;
  reg [ADDR_W-1:2] addrHighReg;
  reg [`SRAM_LANES-1:0] laneSel;
  // Low address bits from the burst sequencer
  wire [1:0] lowAddr;
  wire [ADDR_W-1:0] curAddr;

  // Data phase state
  reg readDrive;
  reg emergeCycle;
  reg [WORD_W-1:0] readWord;

  // Strap synchroniser and latched burst order
  reg strapSync1;
  reg strapSync2;
  reg burstInterleave;
  reg strapTaken;

  // Queue handshakes and entries
  wire pushValid;
  wire pushReady;
  wire [ENTRY_W-1:0] pushEntry;
  wire popValid;
  wire popReady;
  wire [ENTRY_W-1:0] popEntry;
  // Fields of the head entry
  wire [ADDR_W-1:0] popAddr;
  wire [`SRAM_LANES-1:0] popLanes;
  wire [WORD_W-1:0] popWord;
  // Merged words for array write and read forwarding
  wire [WORD_W-1:0] mergedWrite;
  wire [WORD_W-1:0] forwardRead;
  wire [WORD_W-1:0] oldAtPop;
  wire [WORD_W-1:0] oldAtRead;
  wire forwardHit;

  // Nothing but the strap synchroniser and strap capture moves on a masked edge, and only the strap synchroniser flops while frozen
  assign edgeOk = clkEnable & ~clockQualifyN;

  // All three selects must be active together
  assign selectNow = ~chipSelFirstN & chipSelSecond & ~chipSelThirdN;

  // Each active-low select maps to one lane
  assign laneSelNow = {~laneDWriteSelN, ~laneCWriteSelN,
                       ~laneBWriteSelN, ~laneAWriteSelN};

  // Full address of the current beat
  assign curAddr = {addrHighReg, lowAddr};

  // Decode the access kind at a load edge
  always @* begin
    next_loadOp = OP_DESEL;
    if (!selectNow) begin
      // Any inactive select deselects
      next_loadOp = OP_DESEL;
    end else if (!writeEnableN) begin
      // Write enable low starts a write
      next_loadOp = OP_WRITE;
    end else begin
      next_loadOp = OP_READ;
    end
  end

  // Address phase: load or advance on qualified edges only
  always @(posedge core_clk) begin
    if (reset) begin
      opAddr <= OP_DESEL;
      addrHighReg <= {(ADDR_W-2){1'b0}};
      laneSel <= {`SRAM_LANES{1'b0}};
    end else if (edgeOk) begin
      if (!advanceOrLoad) begin
        // Fresh access from the address pins
        opAddr <= next_loadOp;
        addrHighReg <= addrHigh;
      end
      // Advance keeps the access kind; a deselect stays deselected
      // Lane selects are sampled with each beat
      laneSel <= laneSelNow;
    end
  end

  // Burst sequencer for the two low address bits
  sram_burst_counter burstSeq (
    .core_clk(core_clk),
    .reset(reset),
    .edgeOk(edgeOk),
    .load(~advanceOrLoad),
    .advance(advanceOrLoad & (opAddr != OP_DESEL)),
    .interleave(burstInterleave),
    .startLow({burstAddrBit1, burstAddrBit0}),
    .lowAddr(lowAddr)
  );

  // Data phase: output register and driver control
  always @(posedge core_clk) begin
    if (reset) begin
      readDrive <= 1'b0;
      emergeCycle <= 1'b0;
      readWord <= {WORD_W{1'b0}};
    end else if (edgeOk) begin
      // Read data lands one qualified edge after its address
      if (opAddr == OP_READ) begin
        readWord <= forwardRead;
      end
      // Only a read phase drives; write and deselect float
      readDrive <= (opAddr == OP_READ);
      // Mark the first cycle after leaving deselect
      emergeCycle <= (opAddr == OP_DESEL) & ~advanceOrLoad &
                     (next_loadOp != OP_DESEL);
    end
  end

  // Output enable is asynchronous and only gates the drivers
  assign dataOe = readDrive & ~emergeCycle & ~outputEnableN;
  assign parityPinsOe = dataOe;
  assign dataOut = readWord[`SRAM_DATA_W-1:0];
  assign parityPinsOut = readWord[PAR_LSB+`SRAM_LANES-1:PAR_LSB];

  // Strap passes two flops before any use
  always @(posedge core_clk) begin
    strapSync1 <= burstModeStrap;
    strapSync2 <= strapSync1;
  end

  // Burst order taken once after reset, then held static
  always @(posedge core_clk) begin
    if (reset) begin
      burstInterleave <= `SRAM_MODE_RESET;
      strapTaken <= 1'b0;
    end else if (clkEnable && !strapTaken) begin
      burstInterleave <= strapSync2;
      strapTaken <= 1'b1;
    end
  end

  // Write beat pushed at the data edge of a write
  assign pushValid = edgeOk & (opAddr == OP_WRITE);
  assign pushEntry = {curAddr, laneSel, parityPinsIn, dataIn};
  assign writeQueueReady = pushReady;

  // Posted write queue; drain only moves on qualified edges
  sram_write_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH),
    .PTR_W(FIFO_PTR_W)
  ) writeQueue (
    .core_clk(core_clk),
    .reset(reset),
    .clkEnable(clkEnable),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushEntry),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popEntry)
  );

  // Drain stalls with the masked clock as well
  assign popReady = edgeOk;

  // Split the head entry
  assign popAddr = popEntry[ENTRY_W-1:ENTRY_W-ADDR_W];
  assign popLanes = popEntry[WORD_W+`SRAM_LANES-1:WORD_W];
  assign popWord = popEntry[WORD_W-1:0];

  // Old contents for merge and for read
  assign oldAtPop = mem[popAddr];
  assign oldAtRead = mem[curAddr];
  // A read of the word being drained sees the new lanes
  assign forwardHit = popValid & (popAddr == curAddr);

  // Per lane merge of data byte and its parity bit
  genvar g;
  generate
    for (g = 0; g < `SRAM_LANES; g = g + 1) begin : laneMerge
      // Data byte of this lane
      assign mergedWrite[g*LANE_W +: LANE_W] = popLanes[g] ?
        popWord[g*LANE_W +: LANE_W] : oldAtPop[g*LANE_W +: LANE_W];
      // Parity bit of this lane
      assign mergedWrite[PAR_LSB+g] = popLanes[g] ?
        popWord[PAR_LSB+g] : oldAtPop[PAR_LSB+g];
      // Forwarded read, same lane rule
      assign forwardRead[g*LANE_W +: LANE_W] =
        (forwardHit & popLanes[g]) ?
        popWord[g*LANE_W +: LANE_W] : oldAtRead[g*LANE_W +: LANE_W];
      assign forwardRead[PAR_LSB+g] = (forwardHit & popLanes[g]) ?
        popWord[PAR_LSB+g] : oldAtRead[PAR_LSB+g];
    end
  endgenerate

  // Array write from the queue head, unselected lanes kept
  always @(posedge core_clk) begin
    if (popValid && popReady) begin
      mem[popAddr] <= mergedWrite;
    end
  end
endmodule

// ### sim/sync_burst_sram_port_chk.sv
`timescale 1ns/1ps
// Pin-level checks on the data-pin direction and output register
module sync_burst_sram_port_chk (
  // Clock, reset and edge qualifiers
  input wire core_clk, reset, clkEnable, clockQualifyN,
  // Control pins
  input wire advanceOrLoad, writeEnableN,
  input wire chipSelFirstN, chipSelSecond, chipSelThirdN,
  // Direction and read data
  input wire outputEnableN, dataOe, parityPinsOe,
  input wire [31:0] dataOut
);
  // Qualified edge and the kind of load taken there
  wire q = clkEnable && !clockQualifyN;
  wire sel = !chipSelFirstN && chipSelSecond && !chipSelThirdN;
  wire ldOff = q && !advanceOrLoad && !sel;
  wire ldRd = q && !advanceOrLoad && sel && writeEnableN;
  wire ldWr = q && !advanceOrLoad && sel && !writeEnableN;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_OE_OFF: assert property (outputEnableN |-> !dataOe)
    else $error("data driven with output enable high");
  AST_PAR_OE: assert property (parityPinsOe == dataOe)
    else $error("parity lane direction differs from data");
  AST_DESEL: assert property (ldOff ##1 q |=> !dataOe)
    else $error("data driven while deselected");
  AST_WR_PHASE: assert property (ldWr ##1 q |=> !dataOe)
    else $error("data driven in write data phase");
  AST_RD_LAT: assert property (ldRd ##1 q |=> outputEnableN || dataOe)
    else $error("read data not driven one edge after address");
  AST_EMERGE: assert property (ldOff ##1 (ldRd || ldWr) |=> !dataOe)
    else $error("data driven on first cycle after deselect");
  AST_MASK: assert property (!q |=> $stable(dataOut))
    else $error("output register moved on a masked edge");
  AST_STRETCH: assert property (dataOe && !q |=> outputEnableN || dataOe)
    else $error("masked edge dropped the read drive");
  // Main scenarios reached
  COV_READ: cover property (ldRd ##1 q ##1 dataOe);
  COV_WRITE: cover property (ldWr ##1 q);
  COV_STRETCH: cover property (dataOe && !q);
endmodule
bind sync_burst_sram_port sync_burst_sram_port_chk i_chk (.*);

// ### sim/sram_host_model.sv
`timescale 1ns/1ps
// Host controller driving the synchronous pins and sharing the data bus
module sram_host_model (
  // Clock and device outputs
  input wire core_clk,
  input wire [31:0] dataOut,
  input wire [3:0] parityPinsOut,
  input wire dataOe,
  // Pins towards the device
  output reg [17:2] addrHigh,
  output reg burstAddrBit1, burstAddrBit0, writeEnableN, advanceOrLoad,
  output reg clockQualifyN, chipSelFirstN, chipSelSecond, chipSelThirdN,
  output reg laneAWriteSelN, laneBWriteSelN, laneCWriteSelN,
  output reg laneDWriteSelN, outputEnableN,
  output wire [31:0] dataIn,
  output wire [3:0] parityPinsIn
);
  reg [35:0] hostWord = 36'h0; // Word put on the bus by the host
  reg hostDrive = 1'b0; // Host owns the bus this cycle
  reg [35:0] lastBus = 36'h0; // Previous bus value
  // Undriven bus shows the inverse, so a stale value never matches
  wire [35:0] bus = hostDrive ? hostWord :
    dataOe ? {parityPinsOut, dataOut} : ~lastBus;
  assign {parityPinsIn, dataIn} = bus;
  always @(posedge core_clk) lastBus <= bus;
  // Start deselected with a load pending
  initial begin
    {addrHigh, burstAddrBit1, burstAddrBit0} = 18'h0;
    {chipSelFirstN, chipSelSecond, chipSelThirdN} = 3'h6;
    advanceOrLoad = 1'b0;
    writeEnableN = 1'b1;
    clockQualifyN = 1'b0;
    outputEnableN = 1'b0;
    {laneDWriteSelN, laneCWriteSelN, laneBWriteSelN, laneAWriteSelN} = 4'hF;
  end
  // One clock of pin values, set just after the edge
  task beat(input ld, we, input [2:0] cs, input [17:0] a,
    input [3:0] ln, input qn, dr, input [35:0] d);
    begin
      @(posedge core_clk);
      advanceOrLoad <= ~ld;
      writeEnableN <= ~we;
      {chipSelFirstN, chipSelSecond, chipSelThirdN} <= cs;
      {addrHigh, burstAddrBit1, burstAddrBit0} <= a;
      {laneDWriteSelN, laneCWriteSelN, laneBWriteSelN, laneAWriteSelN} <= ~ln;
      clockQualifyN <= qn;
      hostDrive <= dr;
      hostWord <= d;
    end
  endtask
endmodule

// ### sim/sync_burst_sram_port_tb.sv
`timescale 1ns/1ps
// Pin-level bench: host model drives, tasks judge read-back
module sync_burst_sram_port_tb;
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg clkEnable = 1'b1; // Tied: run
  reg burstModeStrap = 1'b1; // Interleaved order until t_linear drives it low
  wire [17:2] addrHigh;
  wire [31:0] dataIn, dataOut;
  wire [3:0] parityPinsIn, parityPinsOut;
  wire burstAddrBit1, burstAddrBit0, writeEnableN, advanceOrLoad;
  wire clockQualifyN, chipSelFirstN, chipSelSecond, chipSelThirdN;
  wire laneAWriteSelN, laneBWriteSelN, laneCWriteSelN, laneDWriteSelN;
  wire outputEnableN, dataOe, parityPinsOe, writeQueueReady;
  integer n_errors = 0;
  integer n_compared = 0;
  integer cycles = 0;
  localparam [2:0] SEL = 3'h2; // All three selects active
  localparam [2:0] OFF = 3'h6;
  localparam [35:0] W1 = 36'h9A5C3F10E;
  localparam [35:0] W2 = 36'h6123456F1;
  always #10 core_clk = ~core_clk;
  sync_burst_sram_port i_sync_burst_sram_port (.*);
  sram_host_model i_sram_host_model (.*);
  // Hang guard, far above the expected run length
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      n_errors = n_errors + 1;
      finish_test;
    end
  end
  task finish_test;
    begin
      $display("Errors %0d, compares %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task check(input [35:0] seen, exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask
  // Lane merge of a partial write
  function [35:0] mix(input [35:0] o, n, input [3:0] ln);
    integer g;
    begin
      mix = o;
      for (g = 0; g < 4; g = g + 1) if (ln[g]) begin
        mix[8*g+:8] = n[8*g+:8];
        mix[32+g] = n[32+g];
      end
    end
  endfunction
  task b(input ld, we, input [2:0] cs, input [17:0] a,
    input [3:0] ln, input qn, dr, input [35:0] d);
    i_sram_host_model.beat(ld, we, cs, a, ln, qn, dr, d);
  endtask
  task wr(input [17:0] a, input [3:0] ln, input [35:0] d);
    begin
      b(1, 1, SEL, a, ln, 0, 0, 0);
      b(1, 0, OFF, 0, 0, 0, 1, d);
    end
  endtask
  task rd(input [17:0] a, input [2:0] cs, input [35:0] e, input eo);
    begin
      b(1, 0, cs, a, 0, 0, 0, 0);
      b(1, 0, OFF, 0, 0, 0, 0, 0);
      b(1, 0, OFF, 0, 0, 0, 0, 0);
      #1;
      check({parityPinsOut, dataOut}, e);
      check(dataOe, eo);
    end
  endtask
  // Write then read back at once, through the data edge
  task t_word;
    begin
      wr(18'h00010, 4'hF, W1);
      rd(18'h00010, SEL, W1, 1);
    end
  endtask
  // Only the selected lanes and their parity bits change
  task t_lanes;
    begin
      wr(18'h00020, 4'hF, W1);
      wr(18'h00020, 4'h5, W2);
      rd(18'h00020, SEL, mix(W1, W2, 4'h5), 1);
    end
  endtask
  // Write on a masked edge leaves the word alone
  task t_mask;
    begin
      b(1, 1, SEL, 18'h00010, 4'hF, 1, 0, 0);
      b(1, 0, OFF, 0, 0, 0, 1, W2);
      rd(18'h00010, SEL, W1, 1);
    end
  endtask
  // Masked edge during read drive holds data and drive
  task t_stretch;
    begin
      b(1, 0, SEL, 18'h00010, 0, 0, 0, 0);
      b(1, 0, OFF, 0, 0, 0, 0, 0);
      b(1, 0, OFF, 0, 0, 1, 0, 0);
      b(1, 0, OFF, 0, 0, 0, 0, 0);
      #1;
      check(dataOe, 1);
      check({parityPinsOut, dataOut}, W1);
    end
  endtask
  // Interleaved burst from low bits 1: order 1, 0, 3, 2
  task t_burst;
    integer n;
    begin
      b(1, 1, SEL, 18'h00041, 4'hF, 0, 0, 0);
      for (n = 0; n < 3; n = n + 1)
        b(0, 1, SEL, 0, 4'hF, 0, 1, W2 + n);
      b(1, 0, OFF, 0, 0, 0, 1, W2 + 3);
      for (n = 0; n < 4; n = n + 1)
        rd(18'h00040 | (n ^ 1), SEL, W2 + n, 1);
    end
  endtask
  // Every select combination; only one selects the device
  task t_desel;
    integer i;
    begin
      // A deselected access leaves the output register holding
      for (i = 0; i < 8; i = i + 1)
        rd(18'h00010, i, (i < SEL) ? W2 + 3 : W1, i == SEL);
    end
  endtask
  // Output enable high keeps the pins as inputs
  task t_oe;
    begin
      i_sram_host_model.outputEnableN <= 1'b1;
      rd(18'h00020, SEL, mix(W1, W2, 4'h5), 0);
      i_sram_host_model.outputEnableN <= 1'b0;
    end
  endtask
  // Strap low through a second reset: linear order 1, 2, 3, 0
  task t_linear;
    integer n;
    begin
      burstModeStrap <= 1'b0;
      reset <= 1'b1;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      b(1, 1, SEL, 18'h00081, 4'hF, 0, 0, 0);
      for (n = 0; n < 3; n = n + 1)
        b(0, 1, SEL, 0, 4'hF, 0, 1, W1 + n);
      b(1, 0, OFF, 0, 0, 0, 1, W1 + 3);
      for (n = 0; n < 4; n = n + 1)
        rd(18'h00080 | ((n + 1) & 3), SEL, W1 + n, 1);
    end
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    t_word;
    t_lanes;
    t_mask;
    t_stretch;
    t_burst;
    t_desel;
    t_oe;
    t_linear;
    finish_test;
  end
endmodule
